/* echo_group_main_control.sv */
/*
  Group 0 main control register of the echo canceller and the group's
  power, bypass, interrupt-mask and output-drive logic.
  The coding and law bits are only handed on to the cancellers; nothing here
  converts samples.
  Assumes a byte host port on ref_clk, PCM samples one word per frame from
  logic on the same clock, and asynchronous pins for frame sync and drive enable.
  Limitations a user must know:
  - clearing the power-up bit during initialization aborts it to power down;
  - the bypass or canceller source is latched per sample at accept, so a mode
    change in mid-stream mixes the two sources for a few words;
  - with write-all set only the group 0 window strobes, then all groups at once;
  - tone interrupts are held off whenever the group is not running.
*/
// Summary of operation
// [R01] With bit 7 set, writes to the group 0 window strobe all sixteen groups alike.
// [R02] Receive-out and send-out drive only while bit 6 and the drive-enable pin are high.
// [R03] The drive-enable bit exists only in the group 0 main control register.
// [R04] Bit 5 set suppresses tone detector interrupts from every canceller.
// [R05] Bit 4 set masks the tone interrupt of canceller B.
// [R06] Bit 3 set masks the tone interrupt of canceller A.
// [R07] Bit 2 selects G.711 companded coding when set, sign-magnitude when clear.
// [R08] Bit 1 selects A-law when set, mu-law when clear.
// [R09] Bit 0 high runs the group; low powers it down and bypasses PCM with two frames delay.
// [R10] A rising edge of bit 0 starts an initialization restoring defaults and clearing taps.
// [R11] Initialization ends within two frames and the host waits that long before setup.
// [R12] The register sits at 400 hex, is 8-bit read/write, and resets to 00 hex.
// [R13] A tone interrupt leaves only when neither the global nor its own mask is set.
`timescale 1ns/1ns
`default_nettype none
module echo_group_main_control
  import egmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  // Host register port
  input wire logic [EGMC_ADDR_W-1:0] hostAddr,
  input wire logic [EGMC_DATA_W-1:0] hostWrData,
  input wire logic hostWrite,
  input wire logic hostRead,
  output logic [EGMC_DATA_W-1:0] hostRdData,
  output logic hostRdValid,
  // Write strobes toward the per-group canceller register files
  output logic [EGMC_GROUPS-1:0] groupWriteSel,
  output logic writeAllActive,
  // Pins
  input wire logic outputDriveEnablePin,
  input wire logic frameSyncPin,
  // Configuration toward the group's cancellers
  output logic pcmCompanded,
  output logic lawIsA,
  output logic cancellerRun,
  output logic initStart,
  output logic initBusy,
  // Tone detector interrupts
  input wire logic toneIrqA,
  input wire logic toneIrqB,
  output logic toneIrqOut,
  // PCM input samples, one per frame
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [EGMC_SAMPLE_W-1:0] rinSample,
  input wire logic [EGMC_SAMPLE_W-1:0] sinSample,
  input wire logic [EGMC_SAMPLE_W-1:0] ecRoutSample,
  input wire logic [EGMC_SAMPLE_W-1:0] ecSoutSample,
  // PCM output samples
  output logic outValid,
  input wire logic outReady,
  output logic [EGMC_SAMPLE_W-1:0] routSample,
  output logic [EGMC_SAMPLE_W-1:0] soutSample,
  output logic routOe,
  output logic soutOe
);

  typedef struct packed {
    // Control byte and host read-back
    logic [EGMC_DATA_W-1:0] ctrl;
    logic [EGMC_DATA_W-1:0] rdData;
    logic rdValid;
    // Group write strobes
    logic [EGMC_GROUPS-1:0] wrSel;
    // Power sequencing
    egmc_pwr_t pwr;
    logic [1:0] frameCnt;
    logic initStart;
    // Pin synchronisers and frame edge history
    logic [1:0] odeSync;
    logic [1:0] frameSync;
    logic frameSeen;
    // Sample pipeline and bypass slot
    logic slot;
    logic pendValid;
    logic pendBypass;
    logic [EGMC_WORD_W-1:0] pendWord;
    // Registered pin controls
    logic oe;
    logic irq;
  } egmc_state_t;

  egmc_state_t st_reg;
  egmc_state_t st_next;

  logic ctrlHit;
  logic [EGMC_DATA_W-1:0] wrMerged;
  logic frameEdge;
  logic bypass;
  logic accept;
  logic bufInReady;
  logic bufInValid;
  logic [EGMC_WORD_W-1:0] bufInWord;
  logic [EGMC_WORD_W-1:0] memRdWord;
  logic [EGMC_WORD_W-1:0] bufOutWord;
  logic [EGMC_GROUP_SEL_W-1:0] groupIdx;
  logic inGroupWindow;
  logic inGroup0Window;
  logic [EGMC_GROUPS-1:0] groupHit;
  logic ctrlWrite;
  logic [1:0] frameCntInc;
  logic initDone;
  logic pendTaken;
  logic driveEnable;
  logic toneGateA;
  logic toneGateB;
  logic toneAny;

  // Host decode
  assign ctrlHit = (hostAddr == EGMC_MAIN_CTRL0_ADDR); // R12
  assign ctrlWrite = hostWrite && ctrlHit; // R12 R03
  assign wrMerged = hostWrData;
  assign groupIdx = hostAddr[EGMC_GROUP_SEL_LSB +: EGMC_GROUP_SEL_W];
  assign inGroupWindow = (hostAddr < EGMC_GROUP_WINDOW_LIMIT);
  assign inGroup0Window = (hostAddr < EGMC_GROUP0_WINDOW_LIMIT);

  // Per-group strobe: own window, or the group 0 window for every group under write-all
  for (genvar g = 0; g < EGMC_GROUPS; g++) begin : g_group_hit
    assign groupHit[g] = st_reg.ctrl[EGMC_BIT_WRITE_ALL] ? inGroup0Window
      : (groupIdx == EGMC_GROUP_SEL_W'(g)); // R01
  end

  // Frame edge seen from the second synchroniser stage and a history bit
  assign frameEdge = st_reg.frameSync[1] && !st_reg.frameSeen;

  // Frame count during initialization; done on the second synchronised frame edge
  assign frameCntInc = st_reg.frameCnt + 2'h1;
  assign initDone = frameEdge && (frameCntInc == EGMC_INIT_FRAMES); // R11

  // Bypass while the group is not running
  assign bypass = (st_reg.pwr != EGMC_PWR_RUN); // R09

  // One sample pair per frame; the pipeline stage and buffer stall the source
  assign sampleReady = bufInReady && !st_reg.pendValid;
  assign accept = sampleValid && sampleReady;

  // Word for the output buffer: delayed input in bypass, canceller output otherwise
  assign bufInValid = st_reg.pendValid;
  assign bufInWord = st_reg.pendBypass ? memRdWord : st_reg.pendWord; // R09

  // Pending word leaves once the buffer has room
  assign pendTaken = st_reg.pendValid && bufInReady;

  // Output drive: register bit AND synchronised pin
  assign driveEnable = st_reg.ctrl[EGMC_BIT_OUT_DRIVE_EN] && st_reg.odeSync[1]; // R02

  // Interrupt gating: per-canceller masks, then the global mask over both
  assign toneGateA = toneIrqA && !st_reg.ctrl[EGMC_BIT_TONE_MASK_A]; // R06
  assign toneGateB = toneIrqB && !st_reg.ctrl[EGMC_BIT_TONE_MASK_B]; // R05
  assign toneAny = (toneGateA || toneGateB) && !st_reg.ctrl[EGMC_BIT_GLOBAL_IRQ_MASK]; // R04 R13

  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.initStart = 1'b0;
    st_next.rdValid = 1'b0;
    st_next.wrSel = '0;

    // Pin synchronisers
    st_next.odeSync = {st_reg.odeSync[0], outputDriveEnablePin};
    st_next.frameSync = {st_reg.frameSync[0], frameSyncPin};
    st_next.frameSeen = st_reg.frameSync[1];

    // Register write: all eight bits are held, reset value 00
    if (ctrlWrite) begin
      st_next.ctrl = wrMerged; // R12 R03
    end

    // Register read: mapped address returns the byte, others read as zero
    if (hostRead) begin
      st_next.rdValid = 1'b1;
      st_next.rdData = ctrlHit ? st_reg.ctrl : EGMC_UNMAPPED_READ; // R12
    end

    // Canceller window writes: strobes from the per-group decode
    if (hostWrite && inGroupWindow) begin
      st_next.wrSel = groupHit; // R01
    end

    // Power sequencing of the group
    case (st_reg.pwr)
      EGMC_PWR_DOWN: begin
        if (st_reg.ctrl[EGMC_BIT_POWER_UP]) begin
          st_next.pwr = EGMC_PWR_INIT; // R10
          st_next.initStart = 1'b1; // R10
          st_next.frameCnt = 2'h0;
        end
      end
      EGMC_PWR_INIT: begin
        if (!st_reg.ctrl[EGMC_BIT_POWER_UP]) begin
          st_next.pwr = EGMC_PWR_DOWN; // R09
        end else if (frameEdge) begin
          st_next.frameCnt = frameCntInc;
          if (initDone) begin
            st_next.pwr = EGMC_PWR_RUN; // R11
          end
        end
      end
      EGMC_PWR_RUN: begin
        if (!st_reg.ctrl[EGMC_BIT_POWER_UP]) begin
          st_next.pwr = EGMC_PWR_DOWN; // R09
        end
      end
      default: begin
        st_next.pwr = EGMC_PWR_DOWN;
      end
    endcase

    // Sample pipeline: capture on accept, hand to buffer once it takes it
    if (accept) begin
      st_next.pendValid = 1'b1;
      st_next.pendBypass = bypass; // R09
      st_next.pendWord = {ecRoutSample, ecSoutSample};
      st_next.slot = !st_reg.slot;
    end else if (pendTaken) begin
      st_next.pendValid = 1'b0;
    end

    // Output drive: register bit AND synchronised pin
    st_next.oe = driveEnable; // R02

    // Interrupt gating, held off while the tone detectors are down
    st_next.irq = toneAny; // R13
    if (bypass) begin
      st_next.irq = 1'b0; // Tone detectors are off while not running
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= '0;
      st_reg.ctrl <= EGMC_MAIN_CTRL0_RESET; // R12
      st_reg.pwr <= EGMC_PWR_DOWN;
    end else begin
      st_reg <= st_next;
    end
  end

  // Two-frame delay line for the bypass path
  egmc_delay_mem u_delay (
    .ref_clk(ref_clk),
    .reset(reset),
    .wrEn(accept),
    .slot(st_reg.slot),
    .wrWord({rinSample, sinSample}),
    .rdWord(memRdWord)
  );

  // Output buffer absorbing receiver stalls
  egmc_skid_buf u_buf (
    .ref_clk(ref_clk),
    .reset(reset),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .inWord(bufInWord),
    .outValid(outValid),
    .outReady(outReady),
    .outWord(bufOutWord)
  );

  // Host read-back
  assign hostRdData = st_reg.rdData;
  assign hostRdValid = st_reg.rdValid;

  // Group strobes and mode bits toward the cancellers
  assign groupWriteSel = st_reg.wrSel;
  assign writeAllActive = st_reg.ctrl[EGMC_BIT_WRITE_ALL]; // R01
  assign pcmCompanded = st_reg.ctrl[EGMC_BIT_FORMAT]; // R07
  assign lawIsA = st_reg.ctrl[EGMC_BIT_LAW]; // R08

  // Power state
  assign cancellerRun = (st_reg.pwr == EGMC_PWR_RUN); // R09
  assign initStart = st_reg.initStart;
  assign initBusy = (st_reg.pwr == EGMC_PWR_INIT); // R11

  // Gated tone interrupt
  assign toneIrqOut = st_reg.irq;

  // PCM words from the buffer and the drive enables
  assign routSample = bufOutWord[EGMC_WORD_W-1 -: EGMC_SAMPLE_W];
  assign soutSample = bufOutWord[EGMC_SAMPLE_W-1:0];
  assign routOe = st_reg.oe; // R02
  assign soutOe = st_reg.oe; // R02

endmodule
`default_nettype wire

/* echo_group_main_control_tb.sv */
/* Self-checking bench for the group 0 main control block.
   Assumes the host model and checker files compile first. */
`timescale 1ns/1ns
`default_nettype none
module echo_group_main_control_tb;
  import egmc_pkg::*;
  logic ref_clk, reset, hostWrite, hostRead, hostRdValid, writeAllActive;
  logic [11:0] hostAddr, ad;
  logic [7:0] hostWrData, hostRdData, rdv, cv;
  logic [15:0] groupWriteSel, selSeen;
  logic outputDriveEnablePin, frameSyncPin, pcmCompanded, lawIsA, cancellerRun;
  logic initStart, initBusy, toneIrqA, toneIrqB, toneIrqOut, sampleValid;
  logic sampleReady, outValid, outReady, routOe, soutOe, wa, refused, selClr;
  logic [7:0] rinSample, sinSample, ecRoutSample, ecSoutSample, routSample, soutSample;
  logic [31:0] rnd = 32'hE90B;
  logic [15:0] expQ[$], gotQ[$];
  int n_mismatch = 0;
  int n_checks = 0;
  int startCnt = 0;
  int i, k;
  echo_group_main_control DUT (.ref_clk, .reset, .hostAddr, .hostWrData,
    .hostWrite, .hostRead, .hostRdData, .hostRdValid, .groupWriteSel,
    .writeAllActive, .outputDriveEnablePin, .frameSyncPin, .pcmCompanded,
    .lawIsA, .cancellerRun, .initStart, .initBusy, .toneIrqA, .toneIrqB,
    .toneIrqOut, .sampleValid, .sampleReady, .rinSample, .sinSample,
    .ecRoutSample, .ecSoutSample, .outValid, .outReady, .routSample,
    .soutSample, .routOe, .soutOe);
  egmc_host_model host (.ref_clk, .hostAddr, .hostWrData, .hostWrite,
    .hostRead, .hostRdData, .hostRdValid);
  // Clock and output monitors
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    selSeen <= selClr ? 16'h0000 : (selSeen | groupWriteSel);
    if (initStart === 1'b1) startCnt <= startCnt + 1;
    if (outValid === 1'b1 && outReady === 1'b1) gotQ.push_back({routSample, soutSample});
  end
  // Helpers: random source, expected interrupt, compare and verdict
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic irqExp(input logic [7:0] c, input logic a, input logic b);
    return !c[5] && ((a && !c[3]) || (b && !c[4]));
  endfunction
  task automatic tick();
    @(posedge ref_clk);
    #5;
  endtask
  // Clear the strobe record at one edge, before the next write
  task automatic clrSel();
    selClr = 1'b1;
    tick();
    selClr = 1'b0;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic frame();
    frameSyncPin = 1'b1;
    repeat (2) tick();
    frameSyncPin = 1'b0;
    repeat (2) tick();
  endtask
  // Watchdog
  initial begin
    #2000000;
    n_mismatch++;
    stop_test();
  end
  // Main sequence
  initial begin
    {reset, outputDriveEnablePin, frameSyncPin, toneIrqA, toneIrqB} = 5'b10000;
    {sampleValid, outReady, rinSample, sinSample} = 18'h00000;
    {ecRoutSample, ecSoutSample, selClr} = 17'h00001;
    repeat (2) tick();
    reset = 1'b0;
    host.rd(12'h400, rdv);
    chk("ctrl reset", 16'h0000, rdv);
    host.rd(12'h401, rdv);
    chk("unmapped rd", 16'h0000, rdv);
    // Random control bytes, group powered down
    for (i = 0; i < 6; i++) begin
      rnd = lfsr(rnd);
      cv = rnd[7:0] & 8'h7E;
      host.wr(12'h400, cv);
      host.rd(12'h400, rdv);
      chk("ctrl rd", cv, rdv);
      chk("format", cv[2], pcmCompanded);
      chk("law", cv[1], lawIsA);
      chk("run", 1'b0, cancellerRun);
    end
    // Group window strobes, single and broadcast
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      wa = i[0];
      host.wr(12'h400, {wa, 7'h00});
      chk("write all", wa, writeAllActive);
      ad = (i < 2) ? 12'h045 : (i == 3) ? {6'h00, rnd[5:0]} : {2'b00, rnd[9:0]};
      clrSel();
      host.wr(ad, rnd[15:8]);
      chk("group sel", wa ? (ad < 12'h040 ? 16'hFFFF : 16'h0000)
        : (16'h0001 << ad[9:6]), selSeen);
    end
    clrSel();
    host.wr(12'h7FF, 8'hA5);
    host.rd(12'h400, rdv);
    chk("high addr sel", 16'h0000, selSeen);
    chk("ctrl kept", 16'h0080, rdv);
    // Power-up: init over two frames, then run
    host.wr(12'h400, 8'h01);
    tick();
    chk("init pulses", 16'h0001, startCnt[15:0]);
    chk("init busy", 1'b1, initBusy);
    frame();
    chk("run early", 1'b0, cancellerRun);
    frame();
    chk("run", 1'b1, cancellerRun);
    chk("init done", 1'b0, initBusy);
    // Interrupt masks against random tone inputs
    for (i = 0; i < 16; i++) begin
      rnd = lfsr(rnd);
      cv = {2'b00, i[2:0], 3'b001};
      host.wr(12'h400, cv);
      toneIrqA = rnd[0];
      toneIrqB = rnd[1];
      tick();
      chk("irq", irqExp(cv, rnd[0], rnd[1]), toneIrqOut);
    end
    // Drive enable bit against the pin
    for (i = 0; i < 4; i++) begin
      host.wr(12'h400, {1'b0, i[1], 6'h01});
      outputDriveEnablePin = i[0];
      repeat (4) tick();
      chk("oe", {2{i[1] & i[0]}}, {routOe, soutOe});
    end
    // Power down: bypass two accepts late, receiver stalls first
    host.wr(12'h400, 8'h00);
    expQ = {16'h0000, 16'h0000};
    refused = 1'b0;
    sampleValid = 1'b1;
    for (i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      {rinSample, sinSample, ecRoutSample, ecSoutSample} = rnd;
      for (k = 0; k < 20 && sampleReady !== 1'b1; k++) begin
        if (k == 8) refused = 1'b1;
        if (k == 8) outReady = 1'b1;
        tick();
      end
      expQ.push_back({rinSample, sinSample});
      tick();
    end
    sampleValid = 1'b0;
    outReady = 1'b1;
    repeat (12) tick();
    chk("stall seen", 1'b1, refused);
    chk("out count", 16'd8, 16'(gotQ.size()));
    for (k = 0; k < 8 && k < gotQ.size(); k++) chk("bypass", expQ[k], gotQ[k]);
    stop_test();
  end
endmodule
`default_nettype wire

/* egmc_chk.sv */
/* Assertions on the group 0 main control ports.
   Assumes the bind below attaches it to the top module. */
`timescale 1ns/1ns
`default_nettype none
module egmc_chk
  import egmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [EGMC_ADDR_W-1:0] hostAddr,
  input wire logic hostWrite,
  input wire logic hostRead,
  input wire logic hostRdValid,
  input wire logic [EGMC_GROUPS-1:0] groupWriteSel,
  input wire logic writeAllActive,
  input wire logic outputDriveEnablePin,
  input wire logic cancellerRun,
  input wire logic initStart,
  input wire logic initBusy,
  input wire logic toneIrqA,
  input wire logic toneIrqB,
  input wire logic toneIrqOut,
  input wire logic routOe,
  input wire logic soutOe
);
  // One clock domain
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // Host port and group strobes
  rd_answer_a: assert property (hostRead |=> hostRdValid)
    else $error("read answer missing");
  wr_one_a: assert property (hostWrite && hostAddr < 12'h400 && !writeAllActive
    |=> $onehot(groupWriteSel))
    else $error("group strobe not single");
  wr_all_a: assert property (hostWrite && hostAddr < 12'h040 && writeAllActive
    |=> &groupWriteSel)
    else $error("broadcast strobe missing");
  wr_none_a: assert property (!hostWrite |=> groupWriteSel == 16'h0000)
    else $error("strobe without write");
  // Drive enable
  oe_pin_a: assert property (!outputDriveEnablePin [*4] |-> !routOe)
    else $error("drive with pin low");
  oe_pair_a: assert property (routOe == soutOe)
    else $error("drive enables differ");
  // Interrupt gating
  irq_idle_a: assert property (!toneIrqA && !toneIrqB |=> !toneIrqOut)
    else $error("interrupt without source");
  irq_run_a: assert property (toneIrqOut |-> cancellerRun || $past(cancellerRun))
    else $error("interrupt while down");
  // Power-up sequence
  init_pulse_a: assert property (initStart |-> initBusy ##1 !initStart)
    else $error("init pulse wrong");
  run_excl_a: assert property (!(cancellerRun && initBusy))
    else $error("run during init");
  cover property (initStart);
  cover property (hostWrite && writeAllActive && hostAddr < 12'h040);
  cover property (toneIrqOut);
endmodule
bind echo_group_main_control egmc_chk chk (.ref_clk(ref_clk), .reset(reset),
  .hostAddr(hostAddr), .hostWrite(hostWrite), .hostRead(hostRead),
  .hostRdValid(hostRdValid), .groupWriteSel(groupWriteSel),
  .writeAllActive(writeAllActive), .outputDriveEnablePin(outputDriveEnablePin),
  .cancellerRun(cancellerRun), .initStart(initStart), .initBusy(initBusy),
  .toneIrqA(toneIrqA), .toneIrqB(toneIrqB), .toneIrqOut(toneIrqOut),
  .routOe(routOe), .soutOe(soutOe));
`default_nettype wire

/* egmc_delay_mem.sv */
/*
  Two-word memory holding PCM words for the two-frame bypass delay.
  Assumes one clock; read data come from a register, read happens before write.
*/
`timescale 1ns/1ns
`default_nettype none
module egmc_delay_mem
  import egmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic wrEn,
  input wire logic slot,
  input wire logic [EGMC_WORD_W-1:0] wrWord,
  output logic [EGMC_WORD_W-1:0] rdWord
);

  typedef struct packed {
    logic [EGMC_BYPASS_FRAMES-1:0][EGMC_WORD_W-1:0] mem;
    logic [EGMC_WORD_W-1:0] rd;
  } egmc_mem_t;

  egmc_mem_t st_reg;
  egmc_mem_t st_next;

  // Old contents of the slot leave on the same access that overwrites it
  always_comb begin
    st_next = st_reg;
    if (wrEn) begin
      st_next.rd = st_reg.mem[slot];
      st_next.mem[slot] = wrWord;
    end
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign rdWord = st_reg.rd;

endmodule
`default_nettype wire

/* egmc_host_model.sv */
/* Host processor model for the byte register port.
   Assumes tasks are entered 5 ns after a rising edge. */
`timescale 1ns/1ns
`default_nettype none
module egmc_host_model
  import egmc_pkg::*;
(
  input wire logic ref_clk,
  output logic [EGMC_ADDR_W-1:0] hostAddr,
  output logic [EGMC_DATA_W-1:0] hostWrData,
  output logic hostWrite,
  output logic hostRead,
  input wire logic [EGMC_DATA_W-1:0] hostRdData,
  input wire logic hostRdValid
);
  // Idle bus
  initial begin
    hostAddr = 12'h000;
    hostWrData = 8'h00;
    hostWrite = 1'b0;
    hostRead = 1'b0;
  end
  // Write: one strobe edge, data scrambled after release
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    hostAddr = a;
    hostWrData = d;
    hostWrite = 1'b1;
    @(posedge ref_clk);
    #5;
    hostWrite = 1'b0;
    hostWrData = ~d;
    @(posedge ref_clk);
    #5;
  endtask
  // Read: data taken with the valid flag a cycle later
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    hostAddr = a;
    hostRead = 1'b1;
    @(posedge ref_clk);
    #5;
    hostRead = 1'b0;
    d = (hostRdValid === 1'b1) ? hostRdData : 8'hXX;
    @(posedge ref_clk);
    #5;
  endtask
endmodule
`default_nettype wire

/* egmc_pkg.sv */
/*
  Constants and types for the group 0 main control block of the echo canceller.
  Assumes a 20 MHz reference clock and byte-wide host register access.
*/
package egmc_pkg;

  // Host port geometry
  localparam int EGMC_ADDR_W = 12;
  localparam int EGMC_DATA_W = 8;
  localparam logic [11:0] EGMC_MAIN_CTRL0_ADDR = 12'h400;
  localparam logic [7:0] EGMC_MAIN_CTRL0_RESET = 8'h00;
  localparam logic [7:0] EGMC_UNMAPPED_READ = 8'h00;

  // Canceller register windows: 16 groups of 64 bytes below the main controls
  localparam int EGMC_GROUPS = 16;
  localparam logic [11:0] EGMC_GROUP_WINDOW_LIMIT = 12'h400;
  localparam logic [11:0] EGMC_GROUP0_WINDOW_LIMIT = 12'h040;
  localparam int EGMC_GROUP_SEL_LSB = 6;
  localparam int EGMC_GROUP_SEL_W = 4;

  // Field positions in the main control byte
  localparam int EGMC_BIT_WRITE_ALL = 7;
  localparam int EGMC_BIT_OUT_DRIVE_EN = 6;
  localparam int EGMC_BIT_GLOBAL_IRQ_MASK = 5;
  localparam int EGMC_BIT_TONE_MASK_B = 4;
  localparam int EGMC_BIT_TONE_MASK_A = 3;
  localparam int EGMC_BIT_FORMAT = 2;
  localparam int EGMC_BIT_LAW = 1;
  localparam int EGMC_BIT_POWER_UP = 0;

  // Timing: initialization lasts two frames; bypass delay is two frames
  localparam logic [1:0] EGMC_INIT_FRAMES = 2'h2;
  localparam int EGMC_BYPASS_FRAMES = 2;
  localparam int EGMC_SAMPLE_W = 8;
  localparam int EGMC_WORD_W = 16;

  // Power state of the group
  typedef enum logic [2:0] {
    EGMC_PWR_DOWN = 3'b001,
    EGMC_PWR_INIT = 3'b010,
    EGMC_PWR_RUN = 3'b100
  } egmc_pwr_t;

endpackage

/* egmc_skid_buf.sv */
/*
  Two-entry buffer with valid/ready on both sides for PCM output words.
  Assumes one clock; a receiver stall fills it and then drops inReady.
*/
`timescale 1ns/1ns
`default_nettype none
module egmc_skid_buf
  import egmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [EGMC_WORD_W-1:0] inWord,
  output logic outValid,
  input wire logic outReady,
  output logic [EGMC_WORD_W-1:0] outWord
);

  typedef struct packed {
    logic [1:0][EGMC_WORD_W-1:0] ent;
    logic [1:0] count;
  } egmc_buf_t;

  egmc_buf_t st_reg;
  egmc_buf_t st_next;
  logic push;
  logic pop;

  // Handshakes: full at two entries, empty at zero
  assign inReady = (st_reg.count != 2'h2);
  assign outValid = (st_reg.count != 2'h0);
  assign outWord = st_reg.ent[0];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Entry 0 is the head; a pop shifts entry 1 down
  always_comb begin
    st_next = st_reg;
    if (pop) begin
      st_next.ent[0] = st_reg.ent[1];
    end
    if (push) begin
      if (pop) begin
        st_next.ent[st_reg.count - 2'h1] = inWord;
      end else begin
        st_next.ent[st_reg.count[0]] = inWord;
      end
    end
    st_next.count = st_reg.count + {1'b0, push} - {1'b0, pop};
  end

  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule
`default_nettype wire
